// ---- design/clock_ctl_pkg.sv ----
// Purpose: shared constants and types of the clock controller register block
// Assumes: APB with byte strobes, 32-bit data, register word index = byte address / 4
// Notes:   reset values are all zero; locks are only cleared by presetn
package clock_ctl_pkg;

  // bus shape
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int STRB_W  = DATA_W / 8;
  localparam int BYTE_W  = 8;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 5;

  // register word indices (byte address is four times the index)
  localparam logic [3:0] IDX_CTRL    = 4'h0;
  localparam logic [3:0] IDX_STATUS  = 4'h1;
  localparam logic [3:0] IDX_CH_CTRL = 4'h2;
  localparam logic [3:0] IDX_GEN_CTL = 4'h4;
  localparam logic [3:0] IDX_GEN_DIV = 4'h8;

  // sizes
  localparam int         NUM_CH      = 64;
  localparam int         NUM_GEN     = 9;
  localparam logic [3:0] GEN_SEL_MAX = 4'h8;

  // field positions
  localparam int SFTRST_BIT  = 0;
  localparam int SYNC_BIT    = 7;
  localparam int CH_IDX_LSB  = 0;
  localparam int CH_IDX_MSB  = 5;
  localparam int GEN_LSB     = 8;
  localparam int GEN_MSB     = 11;
  localparam int CH_EN_BIT   = 14;
  localparam int LOCK_BIT    = 15;
  localparam int GID_LSB     = 0;
  localparam int GID_MSB     = 3;
  localparam int SRC_LSB     = 8;
  localparam int SRC_MSB     = 12;
  localparam int GENEN_BIT   = 16;
  localparam int IDC_BIT     = 17;
  localparam int OOV_BIT     = 18;
  localparam int OE_BIT      = 19;
  localparam int DIVSEL_BIT  = 20;
  localparam int RUNSTBY_BIT = 21;
  localparam int DIV_LSB     = 8;
  localparam int DIV_MSB     = 23;

  // cross-domain write synchronisation time
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         SYNC_TIME_NS  = 120;
  localparam int         SYNC_CYCLES   = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SYNC_CNT_LAST = 3'(SYNC_CYCLES - 1);

  typedef struct packed {
    logic       lock;
    logic       en;
    logic [3:0] gen;
  } ch_cfg_s;

  typedef struct packed {
    logic       runstby;
    logic       divsel;
    logic       oe;
    logic       oov;
    logic       idc;
    logic       genen;
    logic [4:0] src;
  } gen_cfg_s;

  localparam int GEN_CFG_W = $bits(gen_cfg_s);

  typedef enum logic [2:0] {
    SK_NONE    = 3'h0,
    SK_CTRL    = 3'h1,
    SK_CH_EN   = 3'h2,
    SK_GEN_CTL = 3'h3,
    SK_GEN_DIV = 3'h4
  } sync_kind_e;

  typedef struct packed {
    sync_kind_e  kind;
    logic [5:0]  idx;
    logic [15:0] data;
  } pend_s;

  typedef struct packed {
    ch_cfg_s  [NUM_CH-1:0]        ch;
    gen_cfg_s [NUM_GEN-1:0]       gen;
    logic     [NUM_GEN-1:0][15:0] div;
    logic     [NUM_GEN-1:0]       gen_lock;
    logic     [5:0]               ch_sel;
    logic     [3:0]               gctl_sel;
    logic     [3:0]               gdiv_sel;
    logic                         soft_rst;
    pend_s                        pend;
    logic                         pready;
    logic                         pslverr;
    logic     [DATA_W-1:0]        prdata;
  } regs_state_s;

endpackage

// ---- design/byte_lane_merge.sv ----
// Purpose: merge APB write data into the current register view by byte strobe
// Assumes: strobe bit n covers data byte n
// Notes:   lanes without a strobe keep the old value, so 8/16/32-bit writes share one path
`timescale 1ns/100ps
module byte_lane_merge
  import clock_ctl_pkg::*;
(
  // data in
  input  wire logic [DATA_W-1:0] old_word,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [STRB_W-1:0] strb,
  // data out
  output logic      [DATA_W-1:0] merged
);

  // per-lane select
  always_comb begin
    for (int i = 0; i < STRB_W; i++) begin
      merged[i*BYTE_W +: BYTE_W] = strb[i] ? wdata[i*BYTE_W +: BYTE_W]
                                           : old_word[i*BYTE_W +: BYTE_W];
    end
  end

endmodule

// ---- design/sync_tracker.sv ----
// Purpose: track one write synchronisation into the clock domains
// Assumes: a new start only comes while idle
// Notes:   busy covers count and done; done lasts one cycle
`timescale 1ns/100ps
module sync_tracker
  import clock_ctl_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_COUNT = 2'h1,
    ST_DONE  = 2'h3
  } trk_state_e;

  typedef struct packed {
    trk_state_e state;
    logic [2:0] cnt;
  } trk_s;

  trk_s st_r;
  trk_s st_nxt;

  // next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.state)
      ST_IDLE: begin
        if (start) begin
          st_nxt.state = ST_COUNT;
          st_nxt.cnt   = SYNC_CNT_LAST;
        end
      end
      ST_COUNT: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = ST_DONE;
        end else begin
          st_nxt.cnt = st_r.cnt - 3'h1;
        end
      end
      ST_DONE: st_nxt.state = ST_IDLE;
      default: st_nxt.state = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{state: ST_IDLE, cnt: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = (st_r.state != ST_IDLE);
  assign done = (st_r.state == ST_DONE);

endmodule

// ---- design/clock_ctl_regs.sv ----
// Purpose: register interface of a generic clock controller on APB
// Assumes: APB4 with pstrb; registers at word index * 4; one sync in flight at a time
// Notes:   clock muxing, dividers and output pins sit outside this block
`timescale 1ns/100ps
module clock_ctl_regs
  import clock_ctl_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [STRB_W-1:0] pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // system
  input  wire logic              user_reset,
  output logic      [NUM_CH-1:0] ch_enable,
  output logic      [NUM_GEN-1:0] gen_enable
);

  // generator config to its register word
  function automatic logic [DATA_W-1:0] gen_word(gen_cfg_s c, logic [3:0] id);
    logic [DATA_W-1:0] w;
    w = '0;
    w[GID_MSB:GID_LSB] = id;
    w[SRC_MSB:SRC_LSB] = c.src;
    w[GENEN_BIT]       = c.genen;
    w[IDC_BIT]         = c.idc;
    w[OOV_BIT]         = c.oov;
    w[OE_BIT]          = c.oe;
    w[DIVSEL_BIT]      = c.divsel;
    w[RUNSTBY_BIT]     = c.runstby;
    return w;
  endfunction

  // register word to generator config
  function automatic gen_cfg_s gen_cfg(logic [DATA_W-1:0] w);
    gen_cfg_s c;
    c.src     = w[SRC_MSB:SRC_LSB];
    c.genen   = w[GENEN_BIT];
    c.idc     = w[IDC_BIT];
    c.oov     = w[OOV_BIT];
    c.oe      = w[OE_BIT];
    c.divsel  = w[DIVSEL_BIT];
    c.runstby = w[RUNSTBY_BIT];
    return c;
  endfunction

  // reset every unlocked setting; locks themselves stay
  function automatic regs_state_s soft_reset(regs_state_s s);
    regs_state_s r;
    r = s;
    for (int i = 0; i < NUM_CH; i++) begin
      if (!s.ch[i].lock) begin
        r.ch[i] = '0;
      end
    end
    for (int g = 0; g < NUM_GEN; g++) begin
      if (!s.gen_lock[g]) begin
        r.gen[g] = '0;
        r.div[g] = '0;
      end
    end
    r.ch_sel   = '0;
    r.gctl_sel = '0;
    r.gdiv_sel = '0;
    r.soft_rst = 1'h0;
    return r;
  endfunction

  regs_state_s       st_r;
  regs_state_s       st_nxt;
  logic [3:0]        idx;
  logic              mapped;
  logic [DATA_W-1:0] view;
  logic [DATA_W-1:0] m;
  logic [5:0]        new_ch;
  logic [3:0]        new_gen;
  logic [3:0]        gid;
  logic              gen_valid;
  logic              gid_ok;
  logic              ch_wr_ok;
  logic              en_change;
  logic              sync_op;
  logic              wr_done;
  logic              sync_start;
  logic              sync_busy;
  logic              sync_done;

  sync_tracker u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (sync_start),
    .busy    (sync_busy),
    .done    (sync_done)
  );

  byte_lane_merge u_merge (
    .old_word (view),
    .wdata    (pwdata),
    .strb     (pstrb),
    .merged   (m)
  );

  // address decode
  always_comb begin
    idx    = paddr[IDX_MSB:IDX_LSB];
    mapped = (paddr[IDX_LSB-1:0] == '0) && (paddr[ADDR_W-1:IDX_MSB+1] == '0) &&
             (idx == IDX_CTRL || idx == IDX_STATUS || idx == IDX_CH_CTRL ||
              idx == IDX_GEN_CTL || idx == IDX_GEN_DIV);
  end

  // read view of the addressed register, indexed ones through their selector
  always_comb begin
    view = '0;
    unique case (idx)
      IDX_CTRL:    view[SFTRST_BIT] = st_r.soft_rst;
      IDX_STATUS:  view[SYNC_BIT] = sync_busy;
      IDX_CH_CTRL: begin
        view[CH_IDX_MSB:CH_IDX_LSB] = st_r.ch_sel;
        view[GEN_MSB:GEN_LSB]       = st_r.ch[st_r.ch_sel].gen;
        view[CH_EN_BIT]             = st_r.ch[st_r.ch_sel].en;
        view[LOCK_BIT]              = st_r.ch[st_r.ch_sel].lock;
      end
      IDX_GEN_CTL: begin
        view = gen_word('0, st_r.gctl_sel);
        if (st_r.gctl_sel <= GEN_SEL_MAX) begin
          view = gen_word(st_r.gen[st_r.gctl_sel], st_r.gctl_sel);
        end
      end
      IDX_GEN_DIV: begin
        view[GID_MSB:GID_LSB] = st_r.gdiv_sel;
        if (st_r.gdiv_sel <= GEN_SEL_MAX) begin
          view[DIV_MSB:DIV_LSB] = st_r.div[st_r.gdiv_sel];
        end
      end
      default: view = '0;
    endcase
  end

  // write qualification and whether the write needs synchronisation
  always_comb begin
    new_ch    = m[CH_IDX_MSB:CH_IDX_LSB];
    new_gen   = m[GEN_MSB:GEN_LSB];
    gid       = m[GID_MSB:GID_LSB];
    gen_valid = (new_gen <= GEN_SEL_MAX);
    ch_wr_ok  = pstrb[1] && !st_r.ch[new_ch].lock;
    en_change = ch_wr_ok && (m[CH_EN_BIT] != st_r.ch[new_ch].en);
    gid_ok    = (|pstrb[STRB_W-1:1]) && (gid <= GEN_SEL_MAX) && !st_r.gen_lock[gid];
    sync_op   = 1'h0;
    if (pwrite && mapped) begin
      unique case (idx)
        IDX_CTRL:    sync_op = pstrb[0];
        IDX_CH_CTRL: sync_op = en_change;
        IDX_GEN_CTL: sync_op = gid_ok;
        IDX_GEN_DIV: sync_op = gid_ok;
        default:     sync_op = 1'h0;
      endcase
    end
    wr_done    = st_r.pready && pwrite && !st_r.pslverr;
    sync_start = wr_done && sync_op;
  end

  // next state: sync completion, user reset, then the bus
  always_comb begin
    st_nxt = st_r;
    if (sync_done) begin
      unique case (st_r.pend.kind)
        SK_CTRL: begin
          if (st_r.soft_rst) begin
            st_nxt = soft_reset(st_nxt);
          end
        end
        SK_CH_EN:   st_nxt.ch[st_r.pend.idx].en = st_r.pend.data[0];
        SK_GEN_CTL: st_nxt.gen[st_r.pend.idx[3:0]] = gen_cfg_s'(st_r.pend.data[GEN_CFG_W-1:0]);
        SK_GEN_DIV: st_nxt.div[st_r.pend.idx[3:0]] = st_r.pend.data;
        SK_NONE:    st_nxt.pend.kind = SK_NONE;
      endcase
      st_nxt.pend.kind = SK_NONE;
    end
    if (user_reset) begin
      st_nxt = soft_reset(st_nxt);
    end
    if (st_r.pready) begin
      // completion edge: direct fields land here, synchronised ones wait in pend
      st_nxt.pready  = 1'h0;
      st_nxt.pslverr = 1'h0;
      if (wr_done) begin
        unique case (idx)
          IDX_CTRL: begin
            if (pstrb[0]) begin
              st_nxt.pend = '{kind: SK_CTRL, idx: '0, data: '0};
              if (m[SFTRST_BIT]) begin
                st_nxt.soft_rst = 1'h1;
              end
            end
          end
          IDX_CH_CTRL: begin
            if (pstrb[0]) begin
              st_nxt.ch_sel = new_ch;
            end
            if (ch_wr_ok) begin
              if (gen_valid) begin
                st_nxt.ch[new_ch].gen = new_gen;
              end
              if (m[LOCK_BIT]) begin
                st_nxt.ch[new_ch].lock = 1'h1;
                if (gen_valid && new_gen != '0) begin
                  st_nxt.gen_lock[new_gen] = 1'h1;
                end else if (!gen_valid && st_r.ch[new_ch].gen != '0) begin
                  st_nxt.gen_lock[st_r.ch[new_ch].gen] = 1'h1;
                end
              end
              if (en_change) begin
                st_nxt.pend = '{kind: SK_CH_EN, idx: new_ch, data: 16'(m[CH_EN_BIT])};
              end
            end
          end
          IDX_GEN_CTL: begin
            if (pstrb[0]) begin
              st_nxt.gctl_sel = gid;
            end
            if (gid_ok) begin
              st_nxt.pend = '{kind: SK_GEN_CTL, idx: 6'(gid), data: 16'(gen_cfg(m))};
            end
          end
          IDX_GEN_DIV: begin
            if (pstrb[0]) begin
              st_nxt.gdiv_sel = gid;
            end
            if (gid_ok) begin
              st_nxt.pend = '{kind: SK_GEN_DIV, idx: 6'(gid), data: m[DIV_MSB:DIV_LSB]};
            end
          end
          default: st_nxt.pend = st_nxt.pend;                        // status is read-only
        endcase
      end
    end else if (psel && penable && !(sync_op && sync_busy)) begin
      // answer one cycle into the access phase; any width accepted
      st_nxt.pready  = 1'h1;
      st_nxt.pslverr = !mapped;
      st_nxt.prdata  = (mapped && !pwrite) ? view : '0;
    end
  end

  // state register; presetn is the power reset and alone clears locks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state flops
  always_comb begin
    prdata  = st_r.prdata;
    pready  = st_r.pready;
    pslverr = st_r.pslverr;
    for (int i = 0; i < NUM_CH; i++) begin
      ch_enable[i] = st_r.ch[i].en;
    end
    for (int g = 0; g < NUM_GEN; g++) begin
      gen_enable[g] = st_r.gen[g].genen;
    end
  end

  // helpers for the checks below
  logic [NUM_CH-1:0] lock_vec;
  ch_cfg_s           tgt_cfg;
  logic              locked_hit;
  logic              channel_clock_enable_start;

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      lock_vec[i] = st_r.ch[i].lock;
    end
    tgt_cfg     = st_r.ch[new_ch];
    // a channel control write with pstrb[1] to a locked channel at its completion edge, so the error flag is really looked at
    locked_hit  = st_r.pready && pwrite && mapped && idx == IDX_CH_CTRL &&
                  pstrb[1] && tgt_cfg.lock;
    channel_clock_enable_start = sync_start && idx == IDX_CH_CTRL;
  end

  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  AST_SOFT_RST_ZERO_NOP: assert property (
    wr_done && idx == IDX_CTRL && pstrb[0] && !pwdata[SFTRST_BIT] && !st_r.soft_rst
    |=> !st_r.soft_rst && $stable(lock_vec))
    else $error("writing zero to soft reset started a reset");

  AST_SOFT_RST_READS_ONE: assert property (
    wr_done && idx == IDX_CTRL && pstrb[0] && pwdata[SFTRST_BIT] && !user_reset
    |=> st_r.soft_rst && sync_busy)
    else $error("soft reset bit not set during reset");

  AST_SOFT_RST_CLEARS_WITH_SYNC: assert property (
    $fell(st_r.soft_rst) && !$past(user_reset) |-> $fell(sync_busy))
    else $error("soft reset and sync_pending did not clear together");

  AST_SYNC_SET_AND_BOUNDED: assert property (
    sync_start |=> sync_busy[*3] ##[1:2] !sync_busy)
    else $error("sync_pending did not follow the synchronisation");

  AST_LOCK_ONLY_POWER_RESET: assert property (
    (($past(lock_vec) & ~lock_vec) == '0))
    else $error("a config lock was cleared without power reset");

  AST_GEN0_UNLOCKED: assert property (
    wr_done && idx == IDX_CH_CTRL |=> !st_r.gen_lock[0])
    else $error("generator zero became locked");

  AST_LOCKED_CH_KEPT: assert property (
    locked_hit && !sync_done && !user_reset
    |-> !pslverr ##1 (st_r.ch[$past(new_ch)] == $past(tgt_cfg)))
    else $error("write to a locked channel took effect or errored");

  AST_CHANNEL_CLOCK_ENABLE_OLD_UNTIL_SYNC: assert property (
    channel_clock_enable_start |=> (st_r.ch[$past(new_ch)].en == $past(tgt_cfg.en)) && sync_busy)
    else $error("channel enable changed before synchronisation");

  AST_STALL_WHILE_BUSY: assert property (
    psel && penable && !st_r.pready && sync_op && sync_busy |=> !pready)
    else $error("sync write answered while sync_pending");

  AST_LOCK_SETS: assert property (
    wr_done && idx == IDX_CH_CTRL && ch_wr_ok && m[LOCK_BIT] |=> st_r.ch[$past(new_ch)].lock)
    else $error("config lock write did not lock the channel");

  COV_SOFT_RESET_DONE: cover property ($fell(st_r.soft_rst));
  // pready comes two edges after the last stalled cycle is sampled
  COV_BUS_STALL: cover property (psel && penable && sync_op && sync_busy ##2 pready);
  COV_LOCKED_WRITE: cover property (locked_hit);
  COV_CHANNEL_CLOCK_ENABLE_APPLIED: cover property (sync_done && st_r.pend.kind == SK_CH_EN);

endmodule

// ---- sim/tb.sv ----
// Purpose: self-checking bench for the clock controller register block
// Assumes: apb reads return the selected channel or generator instance
// Notes:   random lane data comes from a 32-bit lfsr seeded with 94081
`timescale 1ns/100ps
module tb
  import clock_ctl_pkg::*;
;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata;
  logic [STRB_W-1:0]   pstrb;
  logic [DATA_W-1:0]   prdata;
  logic                pready;
  logic                pslverr;
  logic                user_reset;
  logic [NUM_CH-1:0]   ch_enable;
  logic [NUM_GEN-1:0]  gen_enable;
  logic [DATA_W-1:0]   rdv;
  logic                er;
  logic [31:0]         rnd;
  logic [31:0]         d;
  logic [31:0]         exp_w;
  logic [3:0]          s;
  int                  fails;
  int                  total_checks;

  clock_ctl_regs u_clock_ctl_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .user_reset(user_reset), .ch_enable(ch_enable), .gen_enable(gen_enable)
  );

  // free running bus clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // expected word after a strobed write over an old word
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++)
      if (st[i]) o[i*8 +: 8] = w[i*8 +: 8];
    return o;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dw,
                     input logic [3:0] st);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= dw;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rdv = prdata;
    er  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll the status register until sync_pending drops
  task automatic wait_sync();
    for (int k = 0; k < 20; k++) begin
      apb(1'b0, 8'h04, 32'h0, 4'h0);
      if (rdv[SYNC_BIT] === 1'b0) break;
    end
    if (rdv[SYNC_BIT] !== 1'b0) fails++;
  endtask

  // select an indexed instance with a byte write, then read it
  task automatic rd_idx(input logic [7:0] a, input logic [7:0] id);
    apb(1'b1, a, {24'h0, id}, 4'h1);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    final_report();
  end

  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; pstrb = '0; user_reset = 1'b0;
    fails = 0; total_checks = 0; rnd = 32'd94081;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i == 0 ? 0 : 2 << i), 32'h0, 4'h0);
      chk("reset value", rdv, 32'h0);
    end
    apb(1'b0, 8'h0c, 32'h0, 4'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    $display("test reset and map done");
    // enable channel 5 from generator 3
    apb(1'b1, 8'h08, 32'h00004305, 4'h3);
    chk("enable before sync", {31'h0, ch_enable[5]}, 32'h0);
    apb(1'b0, 8'h04, 32'h0, 4'h0);
    chk("sync pending set", {31'h0, rdv[SYNC_BIT]}, 32'h1);
    wait_sync();
    chk("channel enabled", {31'h0, ch_enable[5]}, 32'h1);
    rd_idx(8'h08, 8'h05);
    chk("channel readback", rdv, 32'h00004305);
    // reserved generator code keeps the old field
    apb(1'b1, 8'h08, 32'h00004007, 4'h3);
    wait_sync();
    apb(1'b1, 8'h08, 32'h00004907, 4'h3);
    rd_idx(8'h08, 8'h07);
    chk("reserved generator", rdv, 32'h00004007);
    $display("test channel config done");
    // random lane writes to generator 2
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      d = (rnd & 32'h003f1f00) | 32'h2;
      apb(1'b1, 8'h10, d, 4'hf);
      wait_sync();
      rnd = lfsr(rnd);
      s = {1'b0, rnd[30:29], 1'b1};
      exp_w = merge(d, (rnd & 32'h003f1f00) | 32'h2, s);
      apb(1'b1, 8'h10, (rnd & 32'h003f1f00) | 32'h2, s);
      wait_sync();
      rd_idx(8'h10, 8'h02);
      chk("generator lanes", rdv, exp_w);
      chk("generator enable", {31'h0, gen_enable[2]}, {31'h0, exp_w[GENEN_BIT]});
    end
    // random divider for generator 4, read back through its selector
    rnd = lfsr(rnd);
    d = (rnd & 32'h00ffff00) | 32'h4;
    apb(1'b1, 8'h20, d, 4'hf);
    wait_sync();
    rd_idx(8'h20, 8'h04);
    chk("divider readback", rdv, d);
    $display("test lane writes done");
    // lock channel 5 with generator 3, lock channel 6 with generator 0
    apb(1'b1, 8'h08, 32'h0000c305, 4'h3);
    wait_sync();
    apb(1'b1, 8'h08, 32'h00000305, 4'h3);
    chk("locked write no error", {31'h0, er}, 32'h0);
    wait_sync();
    chk("locked channel kept", {31'h0, ch_enable[5]}, 32'h1);
    apb(1'b1, 8'h10, 32'h00010003, 4'hf);
    wait_sync();
    chk("locked generator kept", {31'h0, gen_enable[3]}, 32'h0);
    apb(1'b1, 8'h20, 32'h00123403, 4'hf);
    wait_sync();
    rd_idx(8'h20, 8'h03);
    chk("locked divider kept", rdv, 32'h00000003);
    apb(1'b1, 8'h08, 32'h00008006, 4'h3);
    apb(1'b1, 8'h10, 32'h00010000, 4'hf);
    wait_sync();
    chk("generator zero free", {31'h0, gen_enable[0]}, 32'h1);
    $display("test lock done");
    // back to back control writes of zero, the second one stalls
    apb(1'b1, 8'h00, 32'h0, 4'h1);
    apb(1'b1, 8'h00, 32'h0, 4'h1);
    chk("stalled write ok", {31'h0, er}, 32'h0);
    wait_sync();
    chk("zero reset no effect", {31'h0, ch_enable[7]}, 32'h1);
    chk("zero reset gen kept", {31'h0, gen_enable[0]}, 32'h1);
    // soft reset
    apb(1'b1, 8'h00, 32'h1, 4'h1);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk("soft reset ongoing", rdv, 32'h1);
    wait_sync();
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk("soft reset done", rdv, 32'h0);
    chk("unlocked channel reset", {31'h0, ch_enable[7]}, 32'h0);
    chk("generator zero reset", {31'h0, gen_enable[0]}, 32'h0);
    chk("locked channel survives", {31'h0, ch_enable[5]}, 32'h1);
    rd_idx(8'h08, 8'h05);
    chk("locked readback", rdv, 32'h0000c305);
    $display("test soft reset done");
    // user reset spares locked state
    apb(1'b1, 8'h08, 32'h00004007, 4'h3);
    wait_sync();
    @(posedge pclk);
    user_reset <= 1'b1;
    @(posedge pclk);
    user_reset <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("user reset clears", {31'h0, ch_enable[7]}, 32'h0);
    chk("user reset keeps lock", {31'h0, ch_enable[5]}, 32'h1);
    $display("test user reset done");
    final_report();
  end
endmodule
